// [pietr_pkg.sv]
// Constants and types for the prioritized interrupt and event transfer block
package pietr_pkg;
  localparam int NODES = 8;
  localparam int CHANS = 8;
  localparam int NFAST = 2;
  // Trap number of node 0; node i uses base plus i
  localparam logic [6:0] NODE_TRAP_BASE = 7'h10;
  // Upper bound on response time in CPU clocks, used as the assertion and bench wait limit
  localparam int RESP_CYCLES = 8;
  // Register offsets (word index on the register port)
  localparam logic [7:0] OFS_NODE = 8'h00;
  localparam logic [7:0] OFS_SRC  = 8'h10;
  localparam logic [7:0] OFS_DST  = 8'h18;
  localparam logic [7:0] OFS_CNT  = 8'h20;
  localparam logic [7:0] OFS_CCTL = 8'h28;
  localparam logic [7:0] OFS_EDGE = 8'h30;
  localparam logic [7:0] OFS_STAT = 8'h31;
  localparam logic [7:0] OFS_PEND = 8'h32;
  // Node control field positions
  localparam int NC_LVL  = 0;
  localparam int NC_EN   = 6;
  localparam int NC_REQ  = 7;
  localparam int NC_XFER = 8;
  localparam int NC_CH   = 9;
  // Channel control field positions
  localparam int CC_WORD = 0;
  localparam int CC_INCS = 1;
  localparam int CC_INCD = 2;
  localparam int CC_CONT = 3;
  // Reset values and the level given to software trap requests
  localparam logic [15:0] RST_PTR  = 16'h0000;
  localparam logic [7:0]  RST_CNT  = 8'h00;
  localparam logic [3:0]  RST_CCTL = 4'h0;
  localparam logic [3:0]  RST_LVL  = 4'h0;
  localparam logic [3:0]  TRAP_LVL = 4'hf;
  // Edge select codes per fast pin
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef enum logic [1:0] {
    PIETR_IDLE = 2'b01,
    PIETR_WAIT = 2'b10
  } pietr_state_type;

  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic        word;
    logic [2:0]  chan;
  } pietr_xfer_type;
endpackage

// [pietr_top.sv]
// Interrupt arbiter, vectoring and eight-channel event transfer engine
`timescale 1ns/1ps
module pietr_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [15:0]                reg_rdata_q,
  input  wire logic [pietr_pkg::NODES-1:0] periph_req,
  input  wire logic [pietr_pkg::NFAST-1:0] fast_pin,
  input  wire logic                  trap_valid,
  input  wire logic [6:0]            trap_num,
  input  wire logic [3:0]            cpu_level,
  input  wire logic                  cpu_ack,
  output logic                       irq_req_q,
  output logic [8:0]                 irq_vec_q,
  output logic [3:0]                 irq_level_q,
  output logic                       xfer_valid_q,
  output pietr_pkg::pietr_xfer_type  xfer_data_q,
  input  wire logic                  xfer_ready
);
  import pietr_pkg::*;

  // Vector offset from trap number, four bytes per trap
  function automatic logic [8:0] vec_of(input logic [6:0] t);
    return {t, 2'b00};
  endfunction

  // Pointer after a move: step of one byte or one word
  function automatic logic [15:0] ptr_next(input logic [15:0] p, input logic inc,
                                           input logic word);
    logic [15:0] step;
    step = word ? 16'h0002 : 16'h0001;
    return inc ? p + step : p;
  endfunction

  logic [NODES-1:0]  req_q;
  logic [NODES-1:0]  en_q;
  logic [NODES-1:0]  xf_q;
  logic [3:0]        lvl_q [NODES];
  logic [2:0]        nch_q [NODES];
  logic [15:0]       src_q [CHANS];
  logic [15:0]       dst_q [CHANS];
  logic [7:0]        cnt_q [CHANS];
  logic [3:0]        cctl_q [CHANS];
  logic [2*NFAST-1:0] edge_q;
  logic [NFAST-1:0]  s1_q;
  logic [NFAST-1:0]  s2_q;
  logic [NFAST-1:0]  s3_q;
  logic [NFAST-1:0]  stab_q;
  pietr_state_type   st_q;
  logic              trap_pend_q;
  logic [6:0]        trap_num_q;
  logic              irq_trap_q;
  logic [2:0]        irq_idx_q;
  pietr_xfer_type    e1_q;
  logic [1:0]        bcnt_q;
  logic [15:0]       rdata_d;

  // Register decode
  wire        in_node = reg_addr < OFS_SRC;
  wire        in_src  = reg_addr >= OFS_SRC && reg_addr < OFS_DST;
  wire        in_dst  = reg_addr >= OFS_DST && reg_addr < OFS_CNT;
  wire        in_cnt  = reg_addr >= OFS_CNT && reg_addr < OFS_CCTL;
  wire        in_cctl = reg_addr >= OFS_CCTL && reg_addr < OFS_EDGE;
  wire [2:0]  ridx    = reg_addr[2:0];
  wire        wr_node = reg_wr && in_node && reg_addr[3] == 1'b0;

  // Fast pin edges from the agreeing second and third stages
  wire [NFAST-1:0] agree = ~(s2_q ^ s3_q);
  wire [NFAST-1:0] rise  = agree & s3_q & ~stab_q;
  wire [NFAST-1:0] fall  = agree & ~s3_q & stab_q;
  logic [NODES-1:0] fast_hit;
  always_comb begin
    fast_hit = '0;
    for (int f = 0; f < NFAST; f++) begin
      fast_hit[f] = (rise[f] && edge_q[2*f]) || (fall[f] && edge_q[2*f+1]);
    end
  end

  // Arbiter: highest level wins, lower index breaks ties
  logic       win_valid;
  logic [2:0] win_idx;
  logic [3:0] win_lvl;
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 3'h0;
    win_lvl   = 4'h0;
    for (int i = 0; i < NODES; i++) begin
      if (req_q[i] && en_q[i] && (!win_valid || lvl_q[i] > win_lvl)) begin
        win_valid = 1'b1;
        win_idx   = i[2:0];
        win_lvl   = lvl_q[i];
      end
    end
  end

  // Service choice
  wire [2:0] win_ch    = nch_q[win_idx];
  wire       ch_cont   = cctl_q[win_ch][CC_CONT];
  wire       chan_live = cnt_q[win_ch] != 8'h00 || ch_cont;
  wire       buf_rdy   = bcnt_q != 2'h2;
  wire       st_idle   = st_q == PIETR_IDLE;
  wire       do_xfer   = win_valid && xf_q[win_idx] && chan_live && buf_rdy;
  wire       do_trap   = st_idle && trap_pend_q;
  wire       vec_cand  = win_valid && (!xf_q[win_idx] || !chan_live);
  wire       do_vec    = st_idle && !trap_pend_q && vec_cand && win_lvl > cpu_level;
  wire       ack_node  = st_q == PIETR_WAIT && cpu_ack && !irq_trap_q;
  wire [6:0] win_trap  = NODE_TRAP_BASE + {4'h0, win_idx};

  // Winner's channel fields, sampled by the pointer and count checks
  wire [15:0] win_src  = src_q[win_ch];
  wire [7:0]  win_cnt  = cnt_q[win_ch];
  wire        win_incs = cctl_q[win_ch][CC_INCS];
  wire        win_word = cctl_q[win_ch][CC_WORD];

  // Request flags: set wins over any clear
  logic [NODES-1:0] req_set;
  logic [NODES-1:0] req_clr;
  always_comb begin
    for (int i = 0; i < NODES; i++) begin
      req_set[i] = periph_req[i] || fast_hit[i] ||
                   (wr_node && ridx == i[2:0] && reg_wdata[NC_REQ]);
      req_clr[i] = (do_xfer && win_idx == i[2:0]) || (ack_node && irq_idx_q == i[2:0]) ||
                   (wr_node && ridx == i[2:0] && !reg_wdata[NC_REQ]);
    end
  end
  wire [NODES-1:0] req_d = req_set | (req_q & ~req_clr);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q <= '0;
      en_q  <= '0;
      xf_q  <= '0;
      for (int i = 0; i < NODES; i++) begin
        lvl_q[i] <= RST_LVL;
        nch_q[i] <= 3'h0;
      end
    end else begin
      req_q <= req_d;
      if (wr_node) begin
        en_q[ridx]  <= reg_wdata[NC_EN];
        xf_q[ridx]  <= reg_wdata[NC_XFER];
        lvl_q[ridx] <= reg_wdata[NC_LVL +: 4];
        nch_q[ridx] <= reg_wdata[NC_CH +: 3];
      end
    end
  end

  // per-channel state, hardware update wins over software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < CHANS; c++) begin
        src_q[c]  <= RST_PTR;
        dst_q[c]  <= RST_PTR;
        cnt_q[c]  <= RST_CNT;
        cctl_q[c] <= RST_CCTL;
      end
    end else begin
      if (reg_wr && in_src) src_q[ridx] <= reg_wdata;
      if (reg_wr && in_dst) dst_q[ridx] <= reg_wdata;
      if (reg_wr && in_cnt) cnt_q[ridx] <= reg_wdata[7:0];
      if (reg_wr && in_cctl) cctl_q[ridx] <= reg_wdata[3:0];
      if (do_xfer) begin
        src_q[win_ch] <= ptr_next(src_q[win_ch], cctl_q[win_ch][CC_INCS],
                                  cctl_q[win_ch][CC_WORD]);
        dst_q[win_ch] <= ptr_next(dst_q[win_ch], cctl_q[win_ch][CC_INCD],
                                  cctl_q[win_ch][CC_WORD]);
        if (!ch_cont) cnt_q[win_ch] <= cnt_q[win_ch] - 8'h01;
      end
    end
  end

  // Fast pin synchroniser; only stages two and three are looked at
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      stab_q <= '0;
      edge_q <= '0;
    end else begin
      s1_q   <= fast_pin;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      stab_q <= (agree & s3_q) | (~agree & stab_q);
      if (reg_wr && reg_addr == OFS_EDGE) edge_q <= reg_wdata[2*NFAST-1:0];
    end
  end

  // Software trap capture; a new trap while one waits is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_pend_q <= 1'b0;
      trap_num_q  <= 7'h00;
    end else if (trap_valid && !trap_pend_q) begin
      trap_pend_q <= 1'b1;
      trap_num_q  <= trap_num;
    end else if (do_trap) begin
      trap_pend_q <= 1'b0;
    end
  end

  // Vectored request handshake: held until the CPU acknowledges
  // request launched next clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q        <= PIETR_IDLE;
      irq_req_q   <= 1'b0;
      irq_vec_q   <= 9'h000;
      irq_level_q <= 4'h0;
      irq_trap_q  <= 1'b0;
      irq_idx_q   <= 3'h0;
    end else begin
      case (st_q)
        PIETR_IDLE: begin
          if (do_trap) begin
            st_q        <= PIETR_WAIT;
            irq_req_q   <= 1'b1;
            irq_vec_q   <= vec_of(trap_num_q);
            irq_level_q <= TRAP_LVL;
            irq_trap_q  <= 1'b1;
          end else if (do_vec) begin
            st_q        <= PIETR_WAIT;
            irq_req_q   <= 1'b1;
            irq_vec_q   <= vec_of(win_trap);
            irq_level_q <= win_lvl;
            irq_trap_q  <= 1'b0;
            irq_idx_q   <= win_idx;
          end
        end
        PIETR_WAIT: begin
          if (cpu_ack) begin
            st_q      <= PIETR_IDLE;
            irq_req_q <= 1'b0;
          end
        end
        default: st_q <= PIETR_IDLE;
      endcase
    end
  end

  // Two-entry move buffer; head is the output register itself
  pietr_xfer_type xin;
  assign xin.src  = src_q[win_ch];
  assign xin.dst  = dst_q[win_ch];
  assign xin.word = cctl_q[win_ch][CC_WORD];
  assign xin.chan = win_ch;
  wire pop = xfer_valid_q && xfer_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcnt_q       <= 2'h0;
      xfer_valid_q <= 1'b0;
      xfer_data_q  <= '0;
      e1_q         <= '0;
    end else begin
      if (pop && do_xfer) begin
        if (bcnt_q == 2'h1) xfer_data_q <= xin;
        else begin
          xfer_data_q <= e1_q;
          e1_q        <= xin;
        end
      end else if (pop) begin
        xfer_data_q  <= e1_q;
        bcnt_q       <= bcnt_q - 2'h1;
        xfer_valid_q <= bcnt_q == 2'h2;
      end else if (do_xfer) begin
        if (bcnt_q == 2'h0) xfer_data_q <= xin;
        else e1_q <= xin;
        bcnt_q       <= bcnt_q + 2'h1;
        xfer_valid_q <= 1'b1;
      end
    end
  end

  // Read data mux, registered one cycle later
  always_comb begin
    rdata_d = 16'h0000;
    if (in_node && reg_addr[3] == 1'b0) begin
      rdata_d[NC_LVL +: 4] = lvl_q[ridx];
      rdata_d[NC_EN]       = en_q[ridx];
      rdata_d[NC_REQ]      = req_q[ridx];
      rdata_d[NC_XFER]     = xf_q[ridx];
      rdata_d[NC_CH +: 3]  = nch_q[ridx];
    end else if (in_src) rdata_d = src_q[ridx];
    else if (in_dst) rdata_d = dst_q[ridx];
    else if (in_cnt) rdata_d = {8'h00, cnt_q[ridx]};
    else if (in_cctl) rdata_d = {12'h000, cctl_q[ridx]};
    else if (reg_addr == OFS_EDGE) rdata_d = {12'h000, edge_q};
    else if (reg_addr == OFS_STAT) rdata_d = {12'h000, trap_pend_q, !st_idle, bcnt_q};
    else if (reg_addr == OFS_PEND) rdata_d = {8'h00, req_q};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) reg_rdata_q <= 16'h0000;
    else if (reg_rd) reg_rdata_q <= rdata_d;
  end

  AST_RESP: assert property (@(posedge clk) disable iff (rst)
    do_vec |-> ##[1:8] irq_req_q) else $error("vectored request not raised in time");
  AST_ROUTE: assert property (@(posedge clk) disable iff (rst)
    do_xfer |-> xf_q[win_idx] && !do_vec) else $error("transfer on vector-routed node");
  AST_STEAL: assert property (@(posedge clk) disable iff (rst)
    (do_xfer && !irq_req_q && !do_trap) |=> xfer_valid_q && !irq_req_q)
    else $error("transfer branched");
  AST_PTR: assert property (@(posedge clk) disable iff (rst)
    do_xfer |=> src_q[$past(win_ch)] == $past(win_src) +
      ($past(win_incs) ? ($past(win_word) ? 16'h0002 : 16'h0001) : 16'h0000))
    else $error("source pointer wrong");
  AST_CNT: assert property (@(posedge clk) disable iff (rst)
    (do_xfer && !ch_cont) |=> cnt_q[$past(win_ch)] == $past(win_cnt) - 8'h01)
    else $error("count not decremented");
  AST_ZERO: assert property (@(posedge clk) disable iff (rst)
    (win_valid && xf_q[win_idx] && cnt_q[win_ch] == 8'h00 && !ch_cont) |-> !do_xfer)
    else $error("transfer with zero count");
  AST_LVL: assert property (@(posedge clk) disable iff (rst)
    (st_q == PIETR_WAIT && !irq_trap_q) |-> irq_level_q > $past(cpu_level, 1) ||
    $past(st_q) == PIETR_WAIT) else $error("non-preempting level accepted");
  AST_VEC: assert property (@(posedge clk) disable iff (rst)
    (irq_req_q && !irq_trap_q) |-> irq_vec_q == vec_of(NODE_TRAP_BASE + {4'h0, irq_idx_q}))
    else $error("vector offset wrong");
  AST_CLR: assert property (@(posedge clk) disable iff (rst)
    (ack_node && !req_set[irq_idx_q]) |=> !req_q[$past(irq_idx_q)])
    else $error("request not cleared on accept");
endmodule

// [pietr_cpu_model.sv]
// Behavioural CPU sequencer and data mover facing the interrupt block
`timescale 1ns/1ps
module pietr_cpu_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq_req,
  input  wire logic slow,
  output logic      cpu_ack,
  output logic      xfer_ready
);
  logic [3:0] wait_q;

  // Acknowledge after a short or long service entry; one-cycle pulse only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else if (irq_req) begin
      wait_q  <= wait_q + 4'h1;
      cpu_ack <= (wait_q >= (slow ? 4'h5 : 4'h1));
    end
  end

  // Mover stalls for as long as the bench asks, so the buffer must hold
  assign xfer_ready = ~slow;
endmodule

// [tb_prioritized_interrupt_and_event_transfer.sv]
// Self-checking bench for the interrupt arbiter and event transfer engine
`timescale 1ns/1ps
module tb_prioritized_interrupt_and_event_transfer;
  import pietr_pkg::*;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [7:0]            reg_addr = 8'h00;
  logic [15:0]           reg_wdata = 16'h0000;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [15:0]           reg_rdata_q;
  logic [NODES-1:0]      periph_req = '0;
  logic [NFAST-1:0]      fast_pin = '0;
  logic                  trap_valid = 1'b0;
  logic [6:0]            trap_num = 7'h00;
  logic [3:0]            cpu_level = 4'h0;
  logic                  cpu_ack;
  logic                  irq_req_q;
  logic [8:0]            irq_vec_q;
  logic [3:0]            irq_level_q;
  logic                  xfer_valid_q;
  pietr_xfer_type        xfer_data_q;
  logic                  xfer_ready;
  logic                  slow = 1'b0;
  logic [15:0]           d;
  logic [15:0]           p;
  pietr_xfer_type        xq[$];
  int                    err_total = 0;
  int                    checks_done = 0;

  pietr_top u_pietr_top (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .periph_req(periph_req),
    .fast_pin(fast_pin), .trap_valid(trap_valid), .trap_num(trap_num),
    .cpu_level(cpu_level), .cpu_ack(cpu_ack), .irq_req_q(irq_req_q), .irq_vec_q(irq_vec_q),
    .irq_level_q(irq_level_q), .xfer_valid_q(xfer_valid_q), .xfer_data_q(xfer_data_q),
    .xfer_ready(xfer_ready));
  pietr_cpu_model u_pietr_cpu_model (.clk(clk), .rst(rst), .irq_req(irq_req_q),
    .slow(slow), .cpu_ack(cpu_ack), .xfer_ready(xfer_ready));

  // Clock at 200 MHz
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Collect every move the mover accepts
  always @(posedge clk) begin
    if (xfer_valid_q === 1'b1 && xfer_ready === 1'b1) xq.push_back(xfer_data_q);
  end

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe until the next read strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    v = reg_rdata_q;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    check(36'(v), 36'(exp));
  endtask

  task automatic pulse(input logic [NODES-1:0] m);
    @(posedge clk);
    periph_req <= m;
    @(posedge clk);
    periph_req <= '0;
  endtask

  // Wait a bounded time for a vectored request, then let the CPU take it
  task automatic wait_irq(input logic e, input logic [8:0] v, input logic [3:0] l,
                          input int lim);
    int n;
    n = 0;
    while (irq_req_q !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(36'(irq_req_q), 36'(e));
    if (e) begin
      check(36'(irq_vec_q), 36'(v));
      check(36'(irq_level_q), 36'(l));
    end
    n = 0;
    while (irq_req_q !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk_rd(OFS_CNT, 16'h0000);
    wr(8'h08, 16'hffff);
    chk_rd(8'h08, 16'h0000);
    $display("test reset done");
    // Vectored service of node 2, request flag cleared on acceptance
    wr(OFS_NODE + 8'h2, 16'h0045);
    pulse(8'h04);
    wait_irq(1'b1, 9'h048, 4'h5, RESP_CYCLES);
    chk_rd(OFS_NODE + 8'h2, 16'h0045);
    // Software set of a request bit
    wr(OFS_NODE + 8'h5, 16'h00c4);
    wait_irq(1'b1, 9'h054, 4'h4, RESP_CYCLES);
    // Software trap by number
    @(posedge clk);
    trap_valid <= 1'b1;
    trap_num   <= 7'h2a;
    @(posedge clk);
    trap_valid <= 1'b0;
    wait_irq(1'b1, 9'h0a8, TRAP_LVL, RESP_CYCLES);
    $display("test vectored done");
    // Equal level does not preempt running code, one level higher does
    wr(OFS_NODE + 8'h6, 16'h0049);
    cpu_level <= 4'h9;
    pulse(8'h40);
    wait_irq(1'b0, 9'h000, 4'h0, 12);
    cpu_level <= 4'h8;
    wait_irq(1'b1, 9'h058, 4'h9, RESP_CYCLES);
    cpu_level <= 4'h0;
    // Three nodes at once: higher level first, lower index on a tie
    wr(OFS_NODE + 8'h1, 16'h0043);
    wr(OFS_NODE + 8'h4, 16'h0049);
    pulse(8'h52);
    wait_irq(1'b1, 9'h050, 4'h9, RESP_CYCLES);
    wait_irq(1'b1, 9'h058, 4'h9, RESP_CYCLES);
    wait_irq(1'b1, 9'h044, 4'h3, RESP_CYCLES);
    $display("test priority done");
    // Every edge select code on fast pin 0, both edges tried each time
    wr(OFS_NODE, 16'h0042);
    for (int c = 1; c < 4; c++) begin
      wr(OFS_EDGE, 16'(c));
      @(posedge clk);
      fast_pin[0] <= 1'b1;
      wait_irq(c[0], 9'h040, 4'h2, 12);
      @(posedge clk);
      fast_pin[0] <= 1'b0;
      wait_irq(c[1], 9'h040, 4'h2, 12);
    end
    $display("test fast pins done");
    // Word moves on channel 3, count of two, source stepping only
    wr(OFS_SRC + 8'h3, 16'h1000);
    wr(OFS_DST + 8'h3, 16'h2000);
    wr(OFS_CNT + 8'h3, 16'h0002);
    wr(OFS_CCTL + 8'h3, 16'h0003);
    wr(OFS_NODE + 8'h7, 16'h0741);
    for (int k = 0; k < 2; k++) begin
      p = 16'h1000 + 16'(2 * k);
      pulse(8'h80);
      wait_irq(1'b0, 9'h000, 4'h0, RESP_CYCLES);
      check(36'(xq.size()), 36'd1);
      check(xq.pop_front(), {p, 16'h2000, 1'b1, 3'd3});
      chk_rd(OFS_SRC + 8'h3, p + 16'h0002);
      chk_rd(OFS_DST + 8'h3, 16'h2000);
      chk_rd(OFS_CNT + 8'h3, 16'(1 - k));
    end
    pulse(8'h80);
    wait_irq(1'b1, 9'h05c, 4'h1, RESP_CYCLES);
    check(36'(xq.size()), 36'd0);
    $display("test counted transfer done");
    // Continuous byte moves on channel 6 against a stalled mover
    wr(OFS_SRC + 8'h6, 16'h0100);
    wr(OFS_DST + 8'h6, 16'h0200);
    wr(OFS_CCTL + 8'h6, 16'h000e);
    wr(OFS_NODE + 8'h7, 16'h0d41);
    slow <= 1'b1;
    repeat (3) pulse(8'h80);
    rd(OFS_STAT, d);
    check(36'(d[1:0]), 36'd2);
    slow <= 1'b0;
    wait_irq(1'b0, 9'h000, 4'h0, 12);
    check(36'(xq.size()), 36'd3);
    for (int k = 0; k < 3; k++) begin
      p = 16'h0100 + 16'(k);
      check(xq.pop_front(), {p, p + 16'h0100, 1'b0, 3'd6});
    end
    chk_rd(OFS_CNT + 8'h6, 16'h0000);
    chk_rd(OFS_SRC + 8'h6, 16'h0103);
    chk_rd(OFS_SRC + 8'h3, 16'h1004);
    $display("test continuous transfer done");
    close_out();
  end
endmodule
